// File: src/dpe_paging.sv
// Data-space paging: program-memory window, bank select, byte array control
//
// Functional notes
// - Reads at 40h-7Fh return program-memory bytes, not RAM.
// - Program address is window base above the low six data-address bits.
// - Window moves in 64-byte steps across program memory.
// - Window base accepts writes only; reads get no answer.
// - Window base keeps bits 5-0; bits 7-6 are dropped.
// - Reset leaves window base undefined; software writes it first.
// - Bank select at CBh takes byte writes only.
// - One-hot encoding picks array, RAM or display page 1 or 2.
// - Addresses 00h-3Fh go to the same offset in the selected page.
// - Reset leaves bank select untouched; software loads it first.
// - Interrupts and calls leave bank select unchanged.
// - Array access is meaningless with no array page or standby set.
// - Cells are programmed only after write enable is set.
// - Busy reads set for a whole programming cycle; accesses then fail.
// - Idle array reads outside row mode look exactly like ordinary data reads.
// - Byte mode programs one byte; row mode up to eight at once.
// - Byte-mode writes go straight to the addressed cell, no buffer RAM.
// - While busy, control writes are ignored; only busy reads back.
// - An array write with write enable low starts nothing.
// - Setting row mode clears eight latches; writes load them.
// - Row start sets only when write enable and row mode are set.
// - A row is eight bytes sharing array address bits 6-3.
`timescale 1ns/1ps
`include "dpe_regs.svh"
module dpe_paging
   import dpe_pkg::*;
#(
   parameter int PROG_CYCLES = `DPE_PROG_CYCLES
) (
   // Clock and reset
   input  wire logic          clk_sys_in,
   input  wire logic          reset_in,
   // Core data bus
   input  wire dpe_bus_req_t  bus_req_in,
   output logic      [7:0]    rd_data_out,
   output logic               rd_valid_out,
   output logic               rd_hit_out,
   // Program memory window
   output logic      [11:0]   prog_addr_out,
   output logic               prog_rd_out,
   input  wire logic [7:0]    prog_data_in,
   // External banked pages
   output logic      [7:0]    page_sel_out,
   output logic      [5:0]    page_addr_out,
   output logic               page_rd_out,
   output logic               page_wr_out,
   output logic      [7:0]    page_wdata_out,
   input  wire logic [7:0]    page_rdata_in
);

   if (PROG_CYCLES < 9 || PROG_CYCLES > 65535) begin : g_chk
      $error("dpe_paging: PROG_CYCLES out of range");
   end

   localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

   dpe_state_t st_ff;
   dpe_state_t nxt_st;
   dpe_cfg_t   cfg_ff;
   dpe_cfg_t   nxt_cfg;
   logic [7:0] mem_rdata;
   logic       mem_re;
   logic [6:0] mem_raddr;

   // Array page selected by a one-hot bank value
   function automatic logic nvm_sel(input logic [7:0] bank);
      return bank[`DPE_SEL_NVM_PAGE0] | bank[`DPE_SEL_NVM_PAGE1];
   endfunction : nvm_sel

   // Array address: page bit above the in-page offset
   function automatic logic [6:0] nvm_addr(input logic [7:0] bank,
                                           input logic [5:0] off);
      return {bank[`DPE_SEL_NVM_PAGE1], off};
   endfunction : nvm_addr

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   logic in_win;
   logic in_bank;
   logic nvm_hit;
   logic nvm_ok;
   logic ctl_wr;
   assign in_win  = bus_req_in.addr >= `DPE_WIN_LO &&
                    bus_req_in.addr <= `DPE_WIN_HI;
   assign in_bank = bus_req_in.addr <= `DPE_BANK_HI;
   assign nvm_hit = in_bank && nvm_sel(cfg_ff.bank);
   assign nvm_ok  = !st_ff.standby && !st_ff.busy;
   assign ctl_wr  = bus_req_in.wr &&
                    bus_req_in.addr == `DPE_OFF_NVM_CTL;

   // Array read issued at request, data registered in the array
   assign mem_re    = bus_req_in.rd && nvm_hit && nvm_ok;
   assign mem_raddr = nvm_addr(cfg_ff.bank, bus_req_in.addr[5:0]);

   ////////////////////////////////////////////////////////////////////////
   // Write-only paging registers, kept out of reset on purpose

   always_comb begin
      nxt_cfg = cfg_ff;
      if (bus_req_in.wr &&
          bus_req_in.addr == `DPE_OFF_WIN_BASE) begin
         nxt_cfg.win_base = bus_req_in.wdata[5:0];
      end
      if (bus_req_in.wr &&
          bus_req_in.addr == `DPE_OFF_BANK_SEL) begin
         nxt_cfg.bank = bus_req_in.wdata & `DPE_BANK_MASK;
      end
   end

   // No reset: contents stay undefined until software writes them
   always_ff @(posedge clk_sys_in) begin
      cfg_ff <= nxt_cfg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [2:0] ri;
      ri = bus_req_in.addr[2:0];
      nxt_st = st_ff;
      nxt_st.mem_we = 1'b0;
      nxt_st.prog_rd = 1'b0;
      nxt_st.page_rd = 1'b0;
      nxt_st.page_wr = 1'b0;
      nxt_st.rd1 = bus_req_in.rd;
      nxt_st.src1 = DPE_SRC_NONE;
      nxt_st.ctl1 = 8'h00;

      // Read routing, every source answers in the same cycle count
      if (bus_req_in.rd) begin
         if (in_win) begin
            nxt_st.src1 = DPE_SRC_PROG;
            nxt_st.prog_rd = 1'b1;
            nxt_st.prog_addr = {cfg_ff.win_base,
                                bus_req_in.addr[5:0]};
         end else if (nvm_hit) begin
            nxt_st.src1 = (nvm_ok && !st_ff.row_mode) ?
                          DPE_SRC_NVM : DPE_SRC_DEAD;
         end else if (in_bank && cfg_ff.bank != 8'h00) begin
            nxt_st.src1 = DPE_SRC_PAGE;
            nxt_st.page_rd = 1'b1;
            nxt_st.page_addr = bus_req_in.addr[5:0];
         end else if (bus_req_in.addr == `DPE_OFF_NVM_CTL) begin
            // Write-only bits read as zero; only busy is visible
            nxt_st.src1 = DPE_SRC_CTL;
            nxt_st.ctl1[`DPE_CTL_BUSY] = st_ff.busy;
         end
      end

      // Writes to external RAM and display pages
      if (bus_req_in.wr && in_bank && !nvm_sel(cfg_ff.bank) &&
          cfg_ff.bank != 8'h00) begin
         nxt_st.page_wr = 1'b1;
         nxt_st.page_addr = bus_req_in.addr[5:0];
         nxt_st.page_wdata = bus_req_in.wdata;
      end

      // Array writes: dropped unless enabled, awake and idle
      if (bus_req_in.wr && nvm_hit && nvm_ok && st_ff.wr_en) begin
         if (st_ff.row_mode) begin
            // First write fixes the row; other rows are refused
            if (!st_ff.row_held ||
                st_ff.row == {cfg_ff.bank[`DPE_SEL_NVM_PAGE1],
                              bus_req_in.addr[5:3]}) begin
               nxt_st.row_held = 1'b1;
               nxt_st.row = {cfg_ff.bank[`DPE_SEL_NVM_PAGE1],
                             bus_req_in.addr[5:3]};
               nxt_st.row_mask[ri] = 1'b1;
               nxt_st.row_data[ri*8 +: 8] = bus_req_in.wdata;
            end
         end else begin
            // Byte mode: straight to the addressed cell
            nxt_st.byte_job = 1'b1;
            nxt_st.tgt_addr = nvm_addr(cfg_ff.bank,
                                       bus_req_in.addr[5:0]);
            nxt_st.tgt_data = bus_req_in.wdata;
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 16'h0000;
            nxt_st.fsm = DPE_PROG;
         end
      end

      // Control writes, ignored while a cycle runs
      if (ctl_wr && !st_ff.busy) begin
         nxt_st.standby = bus_req_in.wdata[`DPE_CTL_STANDBY];
         nxt_st.wr_en = bus_req_in.wdata[`DPE_CTL_WRITE_EN];
         nxt_st.row_mode = bus_req_in.wdata[`DPE_CTL_ROW_MODE];
         if (bus_req_in.wdata[`DPE_CTL_ROW_MODE] && !st_ff.row_mode) begin
            nxt_st.row_mask = 8'h00;
            nxt_st.row_held = 1'b0;
         end
         // Start only from an already enabled row mode
         if (bus_req_in.wdata[`DPE_CTL_ROW_START] && st_ff.wr_en &&
             st_ff.row_mode && bus_req_in.wdata[`DPE_CTL_ROW_MODE]) begin
            nxt_st.row_start = 1'b1;
            nxt_st.byte_job = 1'b0;
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 16'h0000;
            nxt_st.fsm = DPE_PROG;
         end
      end

      // Programming sequencer
      case (st_ff.fsm)
         DPE_IDLE: begin
         end
         DPE_PROG: begin
            // Cells written over eight edges, from six edges before busy drops to one edge after
            if (st_ff.cnt == PROG_LAST - 16'd8) begin
               nxt_st.fsm = DPE_COMMIT;
               nxt_st.idx = 3'd0;
            end else begin
               nxt_st.cnt = st_ff.cnt + 16'd1;
            end
         end
         DPE_COMMIT: begin
            if (st_ff.byte_job) begin
               nxt_st.mem_we = st_ff.idx == 3'd0;
               nxt_st.mem_waddr = st_ff.tgt_addr;
               nxt_st.mem_wdata = st_ff.tgt_data;
            end else begin
               // Only latches loaded since row mode was set
               nxt_st.mem_we = st_ff.row_mask[st_ff.idx];
               nxt_st.mem_waddr = {st_ff.row, st_ff.idx};
               nxt_st.mem_wdata = st_ff.row_data[st_ff.idx*8 +: 8];
            end
            nxt_st.idx = st_ff.idx + 3'd1;
            if (st_ff.idx == 3'd7) begin
               nxt_st.fsm = DPE_IDLE;
               nxt_st.busy = 1'b0;
               nxt_st.row_start = 1'b0;
               nxt_st.row_mode = 1'b0;
               nxt_st.row_held = 1'b0;
               nxt_st.byte_job = 1'b0;
            end
         end
         default: begin
            nxt_st.fsm = DPE_IDLE;
         end
      endcase

      // Answer stage, one cycle after the sources
      nxt_st.rd_valid = st_ff.rd1;
      nxt_st.rd_hit = st_ff.rd1 && st_ff.src1 != DPE_SRC_NONE;
      case (st_ff.src1)
         DPE_SRC_PROG: nxt_st.rd_data = prog_data_in;
         DPE_SRC_PAGE: nxt_st.rd_data = page_rdata_in;
         DPE_SRC_NVM:  nxt_st.rd_data = mem_rdata;
         DPE_SRC_CTL:  nxt_st.rd_data = st_ff.ctl1;
         default:      nxt_st.rd_data = `DPE_DEAD_DATA;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array and outputs

   dpe_nvm_mem #(
      .DEPTH (128),
      .AW    (7)
   ) u_mem (
      .clk_sys_in (clk_sys_in),
      .we_in      (st_ff.mem_we),
      .waddr_in   (st_ff.mem_waddr),
      .wdata_in   (st_ff.mem_wdata),
      .re_in      (mem_re),
      .raddr_in   (mem_raddr),
      .rdata_out  (mem_rdata)
   );

   assign rd_data_out    = st_ff.rd_data;
   assign rd_valid_out   = st_ff.rd_valid;
   assign rd_hit_out     = st_ff.rd_hit;
   assign prog_addr_out  = st_ff.prog_addr;
   assign prog_rd_out    = st_ff.prog_rd;
   assign page_sel_out   = cfg_ff.bank;
   assign page_addr_out  = st_ff.page_addr;
   assign page_rd_out    = st_ff.page_rd;
   assign page_wr_out    = st_ff.page_wr;
   assign page_wdata_out = st_ff.page_wdata;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_win_read;
      @(posedge clk_sys_in) disable iff (reset_in)
      bus_req_in.rd && in_win |=> prog_rd_out &&
         prog_addr_out == {$past(cfg_ff.win_base),
                           $past(bus_req_in.addr[5:0])};
   endproperty
   a_win_read: assert property (p_win_read)
      else $error("window address not formed from base and offset");

   property p_rd_latency;
      @(posedge clk_sys_in) disable iff (reset_in)
      bus_req_in.rd |-> ##2 rd_valid_out;
   endproperty
   a_rd_latency: assert property (p_rd_latency)
      else $error("read answer not two cycles after request");

   property p_busy_holds;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(st_ff.busy) |-> st_ff.busy [*8];
   endproperty
   a_busy_holds: assert property (p_busy_holds)
      else $error("busy dropped early");

   property p_prog_needs_en;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(st_ff.busy) |-> $past(st_ff.wr_en);
   endproperty
   a_prog_needs_en: assert property (p_prog_needs_en)
      else $error("programming started without write enable");

   property p_ctl_locked;
      @(posedge clk_sys_in) disable iff (reset_in)
      ctl_wr && st_ff.busy |=> st_ff.standby == $past(st_ff.standby) &&
         st_ff.wr_en == $past(st_ff.wr_en);
   endproperty
   a_ctl_locked: assert property (p_ctl_locked)
      else $error("control changed while busy");

   property p_start_gate;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(st_ff.row_start) |-> $past(st_ff.wr_en && st_ff.row_mode);
   endproperty
   a_start_gate: assert property (p_start_gate)
      else $error("row start set without enable and row mode");

   property p_row_clear;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(st_ff.row_mode) |-> st_ff.row_mask == 8'h00;
   endproperty
   a_row_clear: assert property (p_row_clear)
      else $error("row latches not cleared on row mode");

   property p_busy_ends;
      @(posedge clk_sys_in) disable iff (reset_in)
      st_ff.fsm == DPE_COMMIT && st_ff.idx == 3'd7 |=>
         !st_ff.busy && !st_ff.row_mode;
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("busy not cleared at end of cycle");

   property p_bank_stable;
      @(posedge clk_sys_in) disable iff (reset_in)
      $changed(page_sel_out) |->
         $past(bus_req_in.wr && bus_req_in.addr == `DPE_OFF_BANK_SEL);
   endproperty
   a_bank_stable: assert property (p_bank_stable)
      else $error("bank select changed without a write");

endmodule : dpe_paging

// File: src/dpe_regs.svh
// Register offsets, field positions, reset values and timing of the paging block
`ifndef DPE_REGS_SVH
`define DPE_REGS_SVH

// Data-space offsets
`define DPE_WIN_LO         8'h40
`define DPE_WIN_HI         8'h7F
`define DPE_BANK_HI        8'h3F
`define DPE_OFF_WIN_BASE   8'hC9
`define DPE_OFF_BANK_SEL   8'hCB
`define DPE_OFF_NVM_CTL    8'hDF

// Bank select fields
`define DPE_BANK_MASK      8'h7B
`define DPE_SEL_NVM_PAGE0  0
`define DPE_SEL_NVM_PAGE1  1
`define DPE_SEL_RAM_PAGE1  3
`define DPE_SEL_RAM_PAGE2  4
`define DPE_SEL_DISP_PAGE2 5
`define DPE_SEL_DISP_PAGE1 6

// Control register fields
`define DPE_CTL_WRITE_EN   0
`define DPE_CTL_BUSY       1
`define DPE_CTL_ROW_MODE   2
`define DPE_CTL_ROW_START  3
`define DPE_CTL_STANDBY    6
`define DPE_CTL_RESET      8'h00

// Window base width and answer for a meaningless read
`define DPE_WIN_BITS       6
`define DPE_DEAD_DATA      8'h00

// Programming cycle: time in ns, clock period in ns
`define DPE_PROG_TIME_NS   10000
`define DPE_CLK_PERIOD_NS  5
`define DPE_PROG_CYCLES    (`DPE_PROG_TIME_NS / `DPE_CLK_PERIOD_NS)

`endif

// File: src/dpe_pkg.sv
// Types shared by the data-space paging block
package dpe_pkg;

   // Core data-bus request, one cycle
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpe_bus_req_t;

   // Source of a read answer
   typedef enum logic [2:0] {
      DPE_SRC_NONE,
      DPE_SRC_PROG,
      DPE_SRC_PAGE,
      DPE_SRC_NVM,
      DPE_SRC_DEAD,
      DPE_SRC_CTL
   } dpe_src_t;

   // Programming sequencer
   typedef enum logic [1:0] {
      DPE_IDLE,
      DPE_PROG,
      DPE_COMMIT
   } dpe_fsm_t;

   // Registers left undefined by reset
   typedef struct packed {
      logic [5:0] win_base;
      logic [7:0] bank;
   } dpe_cfg_t;

   // All reset state of the paging block
   typedef struct packed {
      dpe_fsm_t    fsm;
      logic        standby;
      logic        wr_en;
      logic        row_mode;
      logic        row_start;
      logic        busy;
      logic [15:0] cnt;
      logic        byte_job;
      logic [6:0]  tgt_addr;
      logic [7:0]  tgt_data;
      logic        row_held;
      logic [3:0]  row;
      logic [7:0]  row_mask;
      logic [63:0] row_data;
      logic [2:0]  idx;
      logic        mem_we;
      logic [6:0]  mem_waddr;
      logic [7:0]  mem_wdata;
      logic        rd1;
      dpe_src_t    src1;
      logic [7:0]  ctl1;
      logic [11:0] prog_addr;
      logic        prog_rd;
      logic [5:0]  page_addr;
      logic        page_rd;
      logic        page_wr;
      logic [7:0]  page_wdata;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        rd_hit;
   } dpe_state_t;

endpackage : dpe_pkg

// File: src/dpe_nvm_mem.sv
// Non-volatile byte array of the paged data space, registered read
`timescale 1ns/1ps
module dpe_nvm_mem
   import dpe_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   // Clock
   input  wire logic          clk_sys_in,
   // Write port
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   // Read port
   input  wire logic          re_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);

   logic [7:0] mem_ff [DEPTH];

   // Depth must fit the address
   if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
      $error("dpe_nvm_mem: DEPTH does not fit AW");
   end

   // Array keeps contents through reset, as the cells would
   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem_ff[waddr_in] <= wdata_in;
      end
      if (re_in) begin
         rdata_out <= mem_ff[raddr_in];
      end
   end

endmodule : dpe_nvm_mem

// File: verif/dpe_mem_model.sv
// Program memory and external page RAM answering the paging block
`timescale 1ns/1ps
module dpe_mem_model (
   // Clock
   input  wire logic        clk_sys_in,
   // Program memory side
   input  wire logic [11:0] prog_addr_in,
   input  wire logic        prog_rd_in,
   output logic      [7:0]  prog_data_out,
   // External page side
   input  wire logic [7:0]  page_sel_in,
   input  wire logic [5:0]  page_addr_in,
   input  wire logic        page_rd_in,
   input  wire logic        page_wr_in,
   input  wire logic [7:0]  page_wdata_in,
   output logic      [7:0]  page_rdata_out
);
   logic [7:0] ram [0:3][0:63];
   logic [1:0] pg;
   logic [7:0] junk_ff = 8'h96;

   // Page index from the one-hot select, highest bit wins
   always_comb begin
      pg = page_sel_in[6] ? 2'h3 : page_sel_in[5] ? 2'h2 :
           page_sel_in[4] ? 2'h1 : 2'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Junk changes every cycle so stale data never passes for an answer
   always_ff @(posedge clk_sys_in) begin
      junk_ff <= ~junk_ff ^ 8'h3C;
      if (page_wr_in) begin
         ram[pg][page_addr_in] <= page_wdata_in;
      end
   end

   // Data only valid in the strobe cycle
   assign prog_data_out  = prog_rd_in ? (prog_addr_in[7:0] ^
      {prog_addr_in[11:8], prog_addr_in[11:8]} ^ 8'h5A) : junk_ff;
   assign page_rdata_out = page_rd_in ? ram[pg][page_addr_in] : ~junk_ff;
endmodule : dpe_mem_model

// File: verif/data_space_paging_eeprom_tb.sv
// Self-checking bench of the data-space paging block
`timescale 1ns/1ps
module data_space_paging_eeprom_tb;
   import dpe_pkg::*;
   localparam int PC = 16;
   logic         clk_sys_in, reset_in;
   dpe_bus_req_t req;
   logic [7:0]   rd_data, page_sel, page_wdata, prog_data, page_rdata;
   logic         rd_valid, rd_hit, prog_rd, page_rd, page_wr;
   logic [11:0]  prog_addr;
   logic [5:0]   page_addr;
   logic [7:0]   shadow [0:8];
   int           error_cnt = 0;
   int           num_checks = 0;
   int           cyc = 0;

   dpe_paging #(.PROG_CYCLES(PC)) DUT (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_req_in(req),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
      .prog_addr_out(prog_addr), .prog_rd_out(prog_rd),
      .prog_data_in(prog_data), .page_sel_out(page_sel),
      .page_addr_out(page_addr), .page_rd_out(page_rd),
      .page_wr_out(page_wr), .page_wdata_out(page_wdata),
      .page_rdata_in(page_rdata));

   dpe_mem_model mem (
      .clk_sys_in(clk_sys_in), .prog_addr_in(prog_addr),
      .prog_rd_in(prog_rd), .prog_data_out(prog_data),
      .page_sel_in(page_sel), .page_addr_in(page_addr),
      .page_rd_in(page_rd), .page_wr_in(page_wr),
      .page_wdata_in(page_wdata), .page_rdata_out(page_rdata));

   ////////////////////////////////////////////////////////////////////////
   // Expected program byte, kept apart from the model on purpose
   function automatic logic [7:0] pm(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
   endfunction : pm

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // One-cycle write, held over the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk_sys_in);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: dat};
      @(posedge clk_sys_in);
      req <= '0;
      @(negedge clk_sys_in); // Registered outputs settled before checks
   endtask : wr

   // Read, then wait a bounded time for the answer pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] q,
                     output logic h);
      int n;
      @(posedge clk_sys_in);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_sys_in);
      req <= '0;
      q = 8'hEE;
      h = 1'bx;
      for (n = 0; n < 4; n++) begin
         @(negedge clk_sys_in);
         if (rd_valid === 1'b1) begin
            q = rd_data;
            h = rd_hit;
            break;
         end
      end
   endtask : rd

   // Poll the control register until busy drops
   task automatic wait_idle();
      logic [7:0] q;
      logic       h;
      int         n;
      for (n = 0; n < 100; n++) begin
         rd(8'hDF, q, h);
         if (q[1] === 1'b0) break;
      end
      chk(q, 8'h00);
   endtask : wait_idle

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   // Main sequence; bank writes stay one-hot or zero and control bits 5-4 stay 0
   initial begin
      logic [7:0] q, a, x, wb, d;
      logic       h;
      int         i, k;
      reset_in = 1'b1;
      req      = '0;
      void'($urandom(32'h8FD5));
      repeat (8) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(negedge clk_sys_in);
      chk({rd_valid, page_rd, page_wr, prog_rd, 4'h0}, 8'h00);
      chk(prog_addr[7:0], 8'h00);
      // Window reads, corner offsets and bases first, junk in bits 7-6
      for (i = 0; i < 24; i++) begin
         wb = (i < 2) ? {2'b11, 6'(i * 63)} : 8'($urandom);
         a  = (i < 2) ? ((i == 0) ? 8'h40 : 8'h7F) : {2'b01, 6'($urandom)};
         wr(8'hC9, wb);
         rd(a, q, h);
         chk(q, pm({wb[5:0], a[5:0]}));
         chk({7'h0, h}, 8'h01);
         chk({2'b00, prog_addr[11:6]}, {2'b00, wb[5:0]});
         chk({2'b00, prog_addr[5:0]}, {2'b00, a[5:0]});
      end
      // Write-only registers give no answer
      rd(8'hC9, q, h);
      chk({h, q[6:0]}, 8'h00);
      rd(8'hCB, q, h);
      chk({h, q[6:0]}, 8'h00);
      // Every RAM and display page
      for (k = 0; k < 4; k++) begin
         x = 8'h08 << k;
         wr(8'hCB, x);
         chk(page_sel, x);
         a = 8'($urandom) & 8'h3F;
         d = 8'($urandom);
         wr(a, d);
         chk({2'b00, page_addr}, a);
         rd(a, q, h);
         chk(q, d);
         rd(8'h45, q, h);
         chk(page_sel, x);
      end
      // Array page 0; a write with enable low starts nothing
      wr(8'hCB, 8'h01);
      wr(8'hDF, 8'h00);
      wr(8'h10, 8'h3C);
      rd(8'hDF, q, h);
      chk(q, 8'h00);
      wr(8'hDF, 8'h01);
      // Byte mode fills one row plus the first byte of the next
      for (i = 0; i < 9; i++) begin
         shadow[i] = 8'($urandom);
         wr(8'h18 + 8'(i), shadow[i]);
         rd(8'hDF, q, h);
         chk(q, 8'h02);
         wr(8'hDF, 8'h40);
         wait_idle();
         rd(8'h18 + 8'(i), q, h);
         chk(q, shadow[i]);
      end
      // Standby and no page give empty answers
      wr(8'hDF, 8'h41);
      rd(8'h18, q, h);
      chk({h, q[6:0]}, 8'h80);
      wr(8'hCB, 8'h00);
      wr(8'hDF, 8'h01);
      rd(8'h18, q, h);
      chk(q, 8'h00);
      wr(8'hCB, 8'h01);
      // Start without row mode is dropped
      wr(8'hDF, 8'h09);
      rd(8'hDF, q, h);
      chk(q, 8'h00);
      // Row mode: three bytes loaded, one off-row write dropped
      wr(8'hDF, 8'h05);
      wr(8'h18, 8'hA1);
      wr(8'h1A, 8'hA2);
      wr(8'h1B, 8'hA3);
      wr(8'h20, 8'h77);
      wr(8'hDF, 8'h0D);
      rd(8'hDF, q, h);
      chk(q, 8'h02);
      wait_idle();
      shadow[0] = 8'hA1;
      shadow[2] = 8'hA2;
      shadow[3] = 8'hA3;
      for (i = 0; i < 9; i++) begin
         rd(8'h18 + 8'(i), q, h);
         chk(q, shadow[i]);
      end
      // Array page 1 holds its own cells, page 0 untouched
      wr(8'hCB, 8'h02);
      d = 8'($urandom);
      wr(8'h18, d);
      wait_idle();
      rd(8'h18, q, h);
      chk(q, d);
      wr(8'hCB, 8'h01);
      rd(8'h18, q, h);
      chk(q, 8'hA1);
      end_sim();
   end
endmodule : data_space_paging_eeprom_tb
